// *** sim/host_model.sv ***
// host model driving register reads and writes on the block's port
module host_model (
    // clock
    input  wire logic          clk_i,
    // register port
    output msc_pkg::host_req_t req_o,
    input  wire logic [7:0]    rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;

    initial req_o = '0;

    function automatic logic [7:0] keep(input logic [2:0] a);
        case (a)
            3'h3:    return 8'h3f;
            3'h4:    return 8'h1f;
            3'h6,
            3'h7:    return 8'h03;
            default: return 8'hff;
        endcase
    endfunction

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        req_o.wr = 1'b1;
        req_o.addr = a;
        req_o.wdata = d & keep(a);
        @(posedge clk_i);
        #1;
        req_o = '0;
    endtask

    // data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        req_o.rd = 1'b1;
        req_o.addr = a;
        @(posedge clk_i);
        #1;
        req_o = '0;
        d = rdata_i;
    endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the misc event block
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic               clk_i, rst_n_i, mse, gee, bmr, gsc, hit;
    logic               sci, sci_irq, smi, gss, bms, tmr;
    logic [7:0]         src_low, rdata, v;
    logic [5:0]         src_high;
    logic [2:0]         edge_in;
    msc_pkg::host_req_t req;
    int                 fails, checks_done, cyc;

    host_model i_host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));

    msc_events i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
        .src_low_i(src_low), .src_high_i(src_high), .edge_in_i(edge_in),
        .master_sci_enable_i(mse), .global_event_enable_i(gee),
        .busmaster_reload_i(bmr), .global_status_clear_i(gsc),
        .sci_o(sci), .sci_irq_o(sci_irq), .smi_o(smi),
        .global_status_set_o(gss), .busmaster_status_o(bms),
        .pm_timer_run_o(tmr)
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // catches one-cycle sci events between checks
    always @(posedge clk_i)
    begin
        if (sci === 1'b1)
            hit <= 1'b1;
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            final_report();
        end
    end

    initial
    begin
        {rst_n_i, mse, gee, bmr, gsc, hit} = '0;
        {src_low, src_high, edge_in} = '0;
        settle(2);
        rst_n_i = 1'b1;
        for (int a = 0; a < 8; a++)
        begin
            i_host.rd(a[2:0], v);
            chk("reset read", (a == 4) ? 8'h02 : 8'h00, v);
        end
        i_host.wr(3'h5, 8'hff);
        i_host.rd(3'h5, v);
        chk("unmapped", 8'h00, v);
        mse = 1'b1;
        for (int i = 0; i < 14; i++)
        begin
            {src_high, src_low} = 14'h1 << i;
            i_host.wr((i < 8) ? 3'h2 : 3'h3, 8'h00);
            settle(2);
            chk("sci masked", 8'h00, {7'h0, sci});
            i_host.wr((i < 8) ? 3'h2 : 3'h3, 8'h01 << (i % 8));
            i_host.rd((i < 8) ? 3'h2 : 3'h3, v);
            chk("enable read", 8'h01 << (i % 8), v);
            chk("sci on", 8'h01, {7'h0, sci});
            chk("sci irq", 8'h01, {7'h0, sci_irq});
            mse = 1'b0;
            settle(2);
            chk("sci master off", 8'h00, {7'h0, sci});
            mse = 1'b1;
            i_host.rd((i < 8) ? 3'h0 : 3'h1, v);
            chk("live status", (i < 8) ? src_low : {2'h0, src_high}, v);
        end
        {src_high, src_low} = '0;
        gee = 1'b1;
        i_host.wr(3'h6, 8'h01);
        hit = 1'b0;
        i_host.wr(3'h7, 8'h01);
        chk("global set", 8'h01, {7'h0, gss});
        settle(2);
        chk("release sci", 8'h01, {7'h0, hit});
        chk("smi", 8'h01, {7'h0, smi});
        i_host.rd(3'h4, v);
        chk("firmware flag", 8'h03, v);
        i_host.wr(3'h4, 8'h00);
        i_host.rd(3'h4, v);
        chk("status zero write", 8'h03, v);
        i_host.wr(3'h4, 8'h03);
        i_host.rd(3'h4, v);
        chk("status one write", 8'h00, v);
        chk("smi cleared", 8'h00, {7'h0, smi});
        i_host.wr(3'h7, 8'h01);
        settle(4);
        chk("release held", 8'h01, {7'h0, smi});
        gsc = 1'b1;
        settle(1);
        gsc = 1'b0;
        settle(2);
        chk("release off", 8'h00, {7'h0, smi});
        i_host.wr(3'h4, 8'h01);
        bmr = 1'b1;
        hit = 1'b0;
        i_host.wr(3'h7, 8'h02);
        settle(2);
        chk("bm status", 8'h01, {7'h0, bms});
        chk("bm sci", 8'h01, {7'h0, hit});
        bmr = 1'b0;
        hit = 1'b0;
        i_host.wr(3'h7, 8'h02);
        settle(2);
        chk("bm no sci", 8'h00, {7'h0, hit});
        i_host.wr(3'h7, 8'h00);
        i_host.rd(3'h7, v);
        chk("control read", 8'h00, v);
        chk("bm held", 8'h01, {7'h0, bms});
        i_host.wr(3'h6, 8'h02);
        settle(1);
        chk("timer on", 8'h01, {7'h0, tmr});
        i_host.wr(3'h6, 8'h00);
        settle(1);
        chk("timer off", 8'h00, {7'h0, tmr});
        for (int i = 0; i < 3; i++)
        begin
            for (int k = 0; k < 2; k++)
            begin
                edge_in[i] = ~edge_in[i];
                settle(3);
                i_host.rd(3'h4, v);
                chk("edge flag", 8'h04 << i, v);
                i_host.wr(3'h4, 8'h04 << i);
                i_host.rd(3'h4, v);
                chk("edge clear", 8'h00, v);
            end
        end
        rst_n_i = 1'b0;
        settle(2);
        rst_n_i = 1'b1;
        i_host.rd(3'h4, v);
        chk("power-on again", 8'h02, v);
        chk("bm after reset", 8'h00, {7'h0, bms});
        i_host.wr(3'h4, 8'h02);
        i_host.rd(3'h4, v);
        chk("power-on clear", 8'h00, v);
        final_report();
    end
endmodule

// *** verilog/msc_events.sv ***
// misc ACPI/legacy event registers, group sci and firmware handshake
// How it works
// - low enable register gates eight sources onto group sci, one per bit.
// - high enable register gates six sources onto group sci.
// - enabled group sci drives the sci irq pin.
// - reserved bits of enable, status and control registers read zero.
// - firmware status flag sets whenever global release is set.
// - smi raised while global release and firmware smi enable are set.
// - writing one to firmware status clears it and global release.
// - power-on flag set by standby reset, cleared by writing one.
// - three edge flags catch either edge, write one clears.
// - after reset status reads 02h, enables and control read 00h.
// - timer run bit: zero stops timer, one lets it run.
// - writing one to firmware release sets global status, sci if enabled.
// - firmware release stays set until global status or firmware status written with one.
// - writing busmaster trigger sets busmaster status; only reset clears it.
// - with busmaster reload set, busmaster trigger also raises sci.
// - peripheral status bits are live, cleared only at the source.
module msc_events (
    // clock and standby power-on reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // host register port
    input  wire msc_pkg::host_req_t   req_i,
    output logic [7:0]                rdata_o,
    // peripheral interrupt sources
    input  wire logic [7:0]           src_low_i,
    input  wire logic [5:0]           src_high_i,
    input  wire logic [2:0]           edge_in_i,
    // bits held in other power-management registers
    input  wire logic                 master_sci_enable_i,
    input  wire logic                 global_event_enable_i,
    input  wire logic                 busmaster_reload_i,
    input  wire logic                 global_status_clear_i,
    // event outputs
    output logic                      sci_o,
    output logic                      sci_irq_o,
    output logic                      smi_o,
    output logic                      global_status_set_o,
    output logic                      busmaster_status_o,
    output logic                      pm_timer_run_o
);
    msc_pkg::state_t q;
    msc_pkg::state_t d;
    logic            grp_low;
    logic            grp_high;
    logic            wr_fw_rel;
    logic            wr_sts;
    logic            wr_bm_trig;

    sci_gate #(.N(8)) u_gate_low (
        .status_i (src_low_i),
        .enable_i (q.en_low),
        .any_o    (grp_low)
    );

    sci_gate #(.N(msc_pkg::N_SRC_HIGH)) u_gate_high (
        .status_i (src_high_i),
        .enable_i (q.en_high[msc_pkg::N_SRC_HIGH-1:0]),
        .any_o    (grp_high)
    );

    function automatic logic hit(input msc_pkg::host_req_t r, input logic [2:0] off);
        hit = r.wr && (r.addr == off);
    endfunction

    assign wr_fw_rel = hit(req_i, msc_pkg::OFF_MISC_CTL) && req_i.wdata[msc_pkg::BIT_FW_REL];
    assign wr_sts     = hit(req_i, msc_pkg::OFF_MISC_STS);
    assign wr_bm_trig = hit(req_i, msc_pkg::OFF_MISC_CTL) && req_i.wdata[msc_pkg::BIT_BM_TRIG];

    always_comb
    begin
        logic [2:0] edges;
        logic       ev_sci;
        logic [7:0] w1c;
        edges  = '0;
        ev_sci = 1'b0;
        w1c    = '0;
        d      = q;
        edges  = q.edge_prev ^ edge_in_i;
        d.edge_prev = edge_in_i;
        if (hit(req_i, msc_pkg::OFF_MASTER_SCI_ENABLE_LOW))
        begin
            d.en_low = req_i.wdata;
        end
        if (hit(req_i, msc_pkg::OFF_MASTER_SCI_ENABLE_HIGH))
        begin
            d.en_high = req_i.wdata & msc_pkg::MASK_EN_HIGH;
        end
        if (hit(req_i, msc_pkg::OFF_MISC_EN))
        begin
            d.misc_en = req_i.wdata & msc_pkg::MASK_MISC_EN;
        end
        if (hit(req_i, msc_pkg::OFF_MISC_STS))
        begin
            w1c = req_i.wdata & msc_pkg::MASK_MISC_STS;
        end
        // write one clears flag and release
        d.misc_sts = q.misc_sts & ~w1c;
        if (w1c[msc_pkg::BIT_FW_STS])
        begin
            d.global_release = 1'b0;
        end
        d.misc_sts[msc_pkg::BIT_EDGE0 +: msc_pkg::N_EDGE] =
            d.misc_sts[msc_pkg::BIT_EDGE0 +: msc_pkg::N_EDGE] | edges;
        // global status write one clears release
        if (global_status_clear_i)
        begin
            d.global_release = 1'b0;
        end
        // write one sets release, sci when enabled
        if (wr_fw_rel)
        begin
            d.global_release = 1'b1;
            ev_sci           = global_event_enable_i;
        end
        if (d.global_release && !q.global_release)
        begin
            d.misc_sts[msc_pkg::BIT_FW_STS] = 1'b1;
        end
        if (global_status_clear_i && !hit(req_i, msc_pkg::OFF_MISC_CTL))
        begin
            d.bm_status = q.bm_status;
        end
        if (hit(req_i, msc_pkg::OFF_MISC_CTL) && req_i.wdata[msc_pkg::BIT_BM_TRIG])
        begin
            d.bm_status = 1'b1;
            ev_sci = ev_sci | busmaster_reload_i;
        end
        d.sci_pulse_pend = ev_sci;
        d.gs_set = wr_fw_rel;
        d.smi = d.global_release && d.misc_en[msc_pkg::BIT_FW_SMI_EN];
        // group sci gated by master enable
        d.sci = master_sci_enable_i && (grp_low || grp_high || q.sci_pulse_pend);
        d.sci_irq = d.sci;
        d.tmr_run = d.misc_en[msc_pkg::BIT_TMR_RUN];
        d.rdata = 8'h00;
        if (req_i.rd)
        begin
            case (req_i.addr)
                msc_pkg::OFF_SCI_STS_LOW:  d.rdata = src_low_i;
                msc_pkg::OFF_SCI_STS_HIGH: d.rdata = {2'h0, src_high_i};
                msc_pkg::OFF_MASTER_SCI_ENABLE_LOW:   d.rdata = q.en_low;
                msc_pkg::OFF_MASTER_SCI_ENABLE_HIGH:  d.rdata = q.en_high;
                msc_pkg::OFF_MISC_STS:     d.rdata = q.misc_sts;
                msc_pkg::OFF_MISC_EN:      d.rdata = q.misc_en;
                // control bits are write-one triggers; read zero
                msc_pkg::OFF_MISC_CTL:     d.rdata = 8'h00;
                default:                   d.rdata = 8'h00;
            endcase
        end
    end

    // reset values; power-on flag set by reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q.en_low         <= msc_pkg::RST_ENABLE;
            q.en_high        <= msc_pkg::RST_ENABLE;
            q.misc_sts       <= msc_pkg::RST_MISC_STS;
            q.misc_en        <= msc_pkg::RST_ENABLE;
            q.global_release <= 1'b0;
            q.bm_status      <= 1'b0;
            q.edge_prev      <= 3'h0;
            q.rdata          <= 8'h00;
            q.sci            <= 1'b0;
            q.sci_pulse_pend <= 1'b0;
            q.smi            <= 1'b0;
            q.sci_irq        <= 1'b0;
            q.tmr_run        <= 1'b0;
            q.gs_set         <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata_o             = q.rdata;
    assign sci_o               = q.sci;
    assign sci_irq_o           = q.sci_irq;
    assign smi_o               = q.smi;
    assign global_status_set_o = q.gs_set;
    assign busmaster_status_o  = q.bm_status;
    assign pm_timer_run_o      = q.tmr_run;

    property p_smi;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |-> (smi_o == (q.global_release && q.misc_en[msc_pkg::BIT_FW_SMI_EN]));
    endproperty
    a_smi: assert property (p_smi) else $error("smi missing");

    property p_fwsts;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(q.global_release) |-> q.misc_sts[0];
    endproperty
    a_fwsts: assert property (p_fwsts) else $error("fw status not set");

    property p_resv;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q.misc_sts[7:5] == 3'h0) && (q.misc_en[7:2] == 6'h00) && (q.en_high[7:6] == 2'h0);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");

    property p_edge;
        @(posedge clk_i) disable iff (!rst_n_i)
        (edge_in_i[0] != q.edge_prev[0]) |=> q.misc_sts[2];
    endproperty
    a_edge: assert property (p_edge) else $error("edge lost");

    property p_rel;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_fw_rel |=> (q.global_release && global_status_set_o);
    endproperty
    a_rel: assert property (p_rel) else $error("release not set");

    property p_bm;
        @(posedge clk_i) disable iff (!rst_n_i)
        (hit(req_i, 3'h7) && req_i.wdata[1]) |=> busmaster_status_o;
    endproperty
    a_bm: assert property (p_bm) else $error("bm status not set");

    property p_tmr;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |-> (pm_timer_run_o == q.misc_en[msc_pkg::BIT_TMR_RUN]);
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer run mismatch");

    property p_irq;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!master_sci_enable_i) |=> !sci_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("sci without master");

    // release write; sci lands two edges on if master still on
    sequence s_rel_event;
        (wr_fw_rel && global_event_enable_i) ##1 master_sci_enable_i;
    endsequence

    sequence s_bm_event;
        (wr_bm_trig && busmaster_reload_i) ##1 master_sci_enable_i;
    endsequence

    property p_rel_sci;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rel_event |=> sci_o;
    endproperty
    a_rel_sci: assert property (p_rel_sci) else $error("release sci missing");

    property p_bm_sci;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_bm_event |=> sci_o;
    endproperty
    a_bm_sci: assert property (p_bm_sci) else $error("busmaster sci missing");

    property p_fw_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_sts && req_i.wdata[msc_pkg::BIT_FW_STS] && !wr_fw_rel)
            |=> (!q.global_release && !q.misc_sts[msc_pkg::BIT_FW_STS]);
    endproperty
    a_fw_clr: assert property (p_fw_clr) else $error("fw status not cleared");

    property p_pwron_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_sts && req_i.wdata[msc_pkg::BIT_PWRON]) |=> !q.misc_sts[msc_pkg::BIT_PWRON];
    endproperty
    a_pwron_clr: assert property (p_pwron_clr) else $error("power-on flag kept");

    property p_pwron_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !q.misc_sts[msc_pkg::BIT_PWRON] |=> !q.misc_sts[msc_pkg::BIT_PWRON];
    endproperty
    a_pwron_hold: assert property (p_pwron_hold) else $error("power-on flag set");

    property p_edge1;
        @(posedge clk_i) disable iff (!rst_n_i)
        (edge_in_i[1] != q.edge_prev[1]) |=> q.misc_sts[3];
    endproperty
    a_edge1: assert property (p_edge1) else $error("edge 1 lost");

    property p_edge2;
        @(posedge clk_i) disable iff (!rst_n_i)
        (edge_in_i[2] != q.edge_prev[2]) |=> q.misc_sts[4];
    endproperty
    a_edge2: assert property (p_edge2) else $error("edge 2 lost");

    property p_edge_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_sts && req_i.wdata[2] && (edge_in_i[0] == q.edge_prev[0])) |=> !q.misc_sts[2];
    endproperty
    a_edge_clr: assert property (p_edge_clr) else $error("edge flag kept");

    property p_gclr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (global_status_clear_i && !wr_fw_rel) |=> !q.global_release;
    endproperty
    a_gclr: assert property (p_gclr) else $error("release not cleared");

    property p_rel_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (q.global_release && !global_status_clear_i
            && !(wr_sts && req_i.wdata[msc_pkg::BIT_FW_STS])) |=> q.global_release;
    endproperty
    a_rel_hold: assert property (p_rel_hold) else $error("release dropped");

    property p_src_low;
        @(posedge clk_i) disable iff (!rst_n_i)
        (master_sci_enable_i && (|(src_low_i & q.en_low))) |=> sci_o;
    endproperty
    a_src_low: assert property (p_src_low) else $error("low source sci missing");

    property p_src_high;
        @(posedge clk_i) disable iff (!rst_n_i)
        (master_sci_enable_i && (|(src_high_i & q.en_high[5:0]))) |=> sci_o;
    endproperty
    a_src_high: assert property (p_src_high) else $error("high source sci missing");

    property p_irq_eq;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |-> (sci_irq_o == sci_o);
    endproperty
    a_irq_eq: assert property (p_irq_eq) else $error("irq pin differs from sci");

    property p_rd_src;
        @(posedge clk_i) disable iff (!rst_n_i)
        (req_i.rd && (req_i.addr == msc_pkg::OFF_SCI_STS_LOW)) |=> (rdata_o == $past(src_low_i));
    endproperty
    a_rd_src: assert property (p_rd_src) else $error("status not live");

    property p_rd_ctl;
        @(posedge clk_i) disable iff (!rst_n_i)
        (req_i.rd && (req_i.addr == msc_pkg::OFF_MISC_CTL)) |=> (rdata_o == 8'h00);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control read not zero");

    property p_bm_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        busmaster_status_o |=> busmaster_status_o;
    endproperty
    a_bm_hold: assert property (p_bm_hold) else $error("bm status dropped");

    property p_tmr_on;
        @(posedge clk_i) disable iff (!rst_n_i)
        (hit(req_i, msc_pkg::OFF_MISC_EN) && req_i.wdata[msc_pkg::BIT_TMR_RUN])
            |=> pm_timer_run_o;
    endproperty
    a_tmr_on: assert property (p_tmr_on) else $error("timer not started");
endmodule

// *** verilog/msc_pkg.sv ***
// shared constants and carrier types for the misc ACPI event block
package msc_pkg;
    localparam int          ADDR_W           = 3;
    localparam logic [2:0]  OFF_SCI_STS_LOW  = 3'h0;
    localparam logic [2:0]  OFF_SCI_STS_HIGH = 3'h1;
    localparam logic [2:0]  OFF_MASTER_SCI_ENABLE_LOW   = 3'h2;
    localparam logic [2:0]  OFF_MASTER_SCI_ENABLE_HIGH  = 3'h3;
    localparam logic [2:0]  OFF_MISC_STS     = 3'h4;
    localparam logic [2:0]  OFF_MISC_EN      = 3'h6;
    localparam logic [2:0]  OFF_MISC_CTL     = 3'h7;
    localparam logic [7:0]  RST_MISC_STS     = 8'h02;
    localparam logic [7:0]  RST_ENABLE       = 8'h00;
    localparam logic [7:0]  MASK_EN_HIGH     = 8'h3f;
    localparam logic [7:0]  MASK_MISC_STS    = 8'h1f;
    localparam logic [7:0]  MASK_MISC_EN     = 8'h03;
    localparam logic [7:0]  MASK_MISC_CTL    = 8'h03;
    localparam int          BIT_FW_STS       = 0;
    localparam int          BIT_PWRON        = 1;
    localparam int          BIT_EDGE0        = 2;
    localparam int          BIT_FW_SMI_EN    = 0;
    localparam int          BIT_TMR_RUN      = 1;
    localparam int          BIT_FW_REL       = 0;
    localparam int          BIT_BM_TRIG      = 1;
    localparam int          N_EDGE           = 3;
    localparam int          N_SRC_HIGH       = 6;

    // host access carrier
    typedef struct packed {
        logic             rd;
        logic             wr;
        logic [2:0]       addr;
        logic [7:0]       wdata;
    } host_req_t;

    // register state of the block
    typedef struct packed {
        logic [7:0]       en_low;
        logic [7:0]       en_high;
        logic [7:0]       misc_sts;
        logic [7:0]       misc_en;
        logic             global_release;
        logic             bm_status;
        logic [2:0]       edge_prev;
        logic [7:0]       rdata;
        logic             sci;
        logic             sci_pulse_pend;
        logic             smi;
        logic             sci_irq;
        logic             tmr_run;
        logic             gs_set;
    } state_t;
endpackage

// *** verilog/sci_gate.sv ***
// status-and-enable gating onto the group sci line
module sci_gate #(
    parameter int N = 8
) (
    // sources
    input  wire logic [N-1:0] status_i,
    input  wire logic [N-1:0] enable_i,
    // result
    output logic              any_o
);
    assign any_o = |(status_i & enable_i);
endmodule
